// ### ack_connectionless_ui_sender.sv
// Acknowledged connectionless UI command sender with retransmission
// How it works
// R1: One busy record shared by both procedures
// R2: Full procedure set always active when running
// R3: Frames carry source and destination addresses
// R4: Source leading bit marks command or response
// R5: All four destination address classes handled
// R6: Source must be individual or special
// R7: Poll bit always set on commands
// R8: Information goes out in UI commands
// R9: Send starts timer, clears transmission count
// R10: Timeout retransmits, bumps count, restarts timer
// R11: Prune group, global and answered addresses
// R12: Keep special 3 unless sole remaining
// R13: Retransmit only if eligible address remains
// R14: Count reaching N4 reports acknowledgment failure
// R15: Final acknowledgment stops timer, zeroes count
// R16: Each exchange owns its timer and count
// R17: Pending set per exchange, done when empty
`timescale 1ns/10ps
module ack_connectionless_ui_sender
   import ui_sender_pkg::*;
#(
   parameter int ACK_TICKS = ui_sender_pkg::ACK_CYCLES,
   parameter int N4        = ui_sender_pkg::N4_DEFAULT
) (
   input  wire logic                             ref_clk,
   input  wire logic                             reset,
   input  wire logic [ui_sender_pkg::ADDR_W-1:0] src_addr,
   input  wire logic                             dest_valid,
   input  wire logic [ui_sender_pkg::ADDR_W-1:0] dest_addr,
   output logic                                  dest_ready,
   input  wire logic                             pay_valid,
   input  wire logic [ui_sender_pkg::BYTE_W-1:0] pay_data,
   input  wire logic                             pay_last,
   output logic                                  pay_ready,
   output logic                                  tx_valid,
   output logic      [ui_sender_pkg::BYTE_W-1:0] tx_data,
   output logic                                  tx_last,
   input  wire logic                             tx_ready,
   input  wire logic                             resp_valid,
   input  wire logic [ui_sender_pkg::ADDR_W-1:0] resp_src,
   input  wire logic                             resp_cr,
   input  wire logic [ui_sender_pkg::BYTE_W-1:0] resp_ctrl,
   input  wire logic                             t1_stat_valid,
   input  wire logic [ui_sender_pkg::ADDR_W-1:0] t1_stat_addr,
   input  wire logic                             t1_stat_busy,
   input  wire logic [ui_sender_pkg::ADDR_W-1:0] stat_query_addr,
   output logic                                  stat_busy,
   output logic                                  done_valid,
   output logic      [1:0]                       done_code,
   output logic                                  engine_busy
);
   import ui_sender_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOAD,
      ST_TX_SRC,
      ST_TX_DST,
      ST_TX_CTL,
      ST_TX_PAY,
      ST_WAIT
   } state_t;

   typedef struct packed {
      state_t                             state;
      logic [MAX_DEST-1:0][ADDR_W-1:0]    dst;
      logic [MAX_DEST-1:0]                used;
      logic [MAX_DEST-1:0]                pend;
      logic [DEST_IDX_W:0]                ndst;
      logic [PAY_DEPTH-1:0][BYTE_W-1:0]   pay;
      logic [PAY_IDX_W-1:0]               plen;
      logic [PAY_IDX_W-1:0]               idx;
      logic [TIMER_W-1:0]                 timer;
      logic [CNT_W-1:0]                   txcnt;
      logic [STATIONS-1:0]                remote_busy;
      logic                               tx_valid;
      logic [BYTE_W-1:0]                  tx_data;
      logic                               tx_last;
      logic                               done_valid;
      logic [1:0]                         done_code;
      logic                               stat_busy;
   } sender_state_t;

   sender_state_t r_reg;
   sender_state_t r_next;

   logic              fifo_valid;
   logic [FIFO_W-1:0] fifo_data;
   logic              fifo_ready;

   localparam logic [TIMER_W-1:0] ACK_LOAD = TIMER_W'(ACK_TICKS);
   localparam logic [CNT_W-1:0]   N4_MAX   = CNT_W'(N4);

   // Acknowledgment expected only from individual and non-3 special
   function automatic logic expects_ack(input logic [ADDR_W-1:0] a);
      addr_kind_t k;
      k = addr_kind(a);
      return (k == AK_INDIVIDUAL) || (k == AK_SPECIAL && a != SPECIAL_ACKLESS);
   endfunction : expects_ack

   function automatic logic [DEST_IDX_W-1:0] last_used(input logic [MAX_DEST-1:0] u);
      logic [DEST_IDX_W-1:0] l;
      l = '0;
      for (int i = 0; i < MAX_DEST; i++) begin
         if (u[i]) begin
            l = DEST_IDX_W'(i);
         end
      end
      return l;
   endfunction : last_used

   ui_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (pay_valid),
      .in_data   ({pay_last, pay_data}),
      .in_ready  (pay_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_ready)
   );

   // Payload drained only between exchanges, so the FIFO backs up
   assign fifo_ready  = (r_reg.state == ST_IDLE) || (r_reg.state == ST_LOAD);
   assign dest_ready  = (r_reg.state == ST_IDLE) && (r_reg.ndst < (DEST_IDX_W + 1)'(MAX_DEST));
   assign tx_valid    = r_reg.tx_valid;
   assign tx_data     = r_reg.tx_data;
   assign tx_last     = r_reg.tx_last;
   assign done_valid  = r_reg.done_valid;
   assign done_code   = r_reg.done_code;
   assign stat_busy   = r_reg.stat_busy;
   assign engine_busy = (r_reg.state != ST_IDLE) && (r_reg.state != ST_LOAD);

   always_comb begin
      logic                  can_emit;
      logic                  src_ok;
      logic                  is_last;
      logic [MAX_DEST-1:0]   keep;
      logic                  eligible;
      logic [DEST_IDX_W-1:0] di;
      can_emit = !r_reg.tx_valid || tx_ready;
      src_ok   = (addr_kind(src_addr) == AK_INDIVIDUAL) || (addr_kind(src_addr) == AK_SPECIAL); // [R6]
      is_last  = 1'b0;
      keep     = '0;
      eligible = 1'b0;
      di       = r_reg.idx[DEST_IDX_W-1:0];

      r_next            = r_reg;
      r_next.done_valid = 1'b0;
      if (r_reg.tx_valid && tx_ready) begin
         r_next.tx_valid = 1'b0;
         r_next.tx_last  = 1'b0;
      end

      // Shared remote status record, Type 1 updates included
      if (t1_stat_valid) begin
         r_next.remote_busy[t1_stat_addr] = t1_stat_busy; // [R1]
      end
      if (resp_valid && resp_cr == CR_RESPONSE && (resp_ctrl == URR_CTRL || resp_ctrl == URNR_CTRL)) begin // [R4]
         r_next.remote_busy[resp_src] = (resp_ctrl == URNR_CTRL); // [R1]
         if (r_reg.state != ST_IDLE && r_reg.state != ST_LOAD) begin
            for (int i = 0; i < MAX_DEST; i++) begin
               if (r_reg.used[i] && r_reg.dst[i] == resp_src) begin
                  r_next.pend[i] = 1'b0; // [R17]
               end
            end
         end
      end
      r_next.stat_busy = r_reg.remote_busy[stat_query_addr];

      // Whole procedure set runs whenever out of reset
      case (r_reg.state) // [R2]
         ST_IDLE, ST_LOAD: begin
            if (r_reg.state == ST_IDLE && dest_valid && dest_ready) begin
               r_next.dst[r_reg.ndst[DEST_IDX_W-1:0]]  = dest_addr; // [R5]
               r_next.used[r_reg.ndst[DEST_IDX_W-1:0]] = 1'b1;
               r_next.pend[r_reg.ndst[DEST_IDX_W-1:0]] = expects_ack(dest_addr); // [R17]
               r_next.ndst = r_reg.ndst + 1'b1;
            end
            if (fifo_valid) begin
               r_next.state = ST_LOAD;
               if (r_reg.plen < PAY_IDX_W'(PAY_DEPTH)) begin
                  r_next.pay[r_reg.plen[PAY_IDX_W-2:0]] = fifo_data[BYTE_W-1:0];
                  r_next.plen = r_reg.plen + 1'b1;
               end
               if (fifo_data[FIFO_W-1]) begin
                  if (!src_ok || r_reg.ndst == '0) begin
                     r_next.state      = ST_IDLE; // [R6]
                     r_next.done_valid = 1'b1;
                     r_next.done_code  = DONE_REJECT;
                     r_next.used       = '0;
                     r_next.pend       = '0;
                     r_next.ndst       = '0;
                     r_next.plen       = '0;
                  end else begin
                     r_next.state = ST_TX_SRC;
                     r_next.txcnt = '0; // [R9] [R16]
                  end
               end
            end
         end
         ST_TX_SRC: begin
            if (can_emit) begin
               r_next.tx_valid = 1'b1;
               r_next.tx_data  = {src_addr, CR_COMMAND}; // [R3] [R4]
               r_next.tx_last  = 1'b0;
               r_next.idx      = '0;
               r_next.state    = ST_TX_DST;
            end
         end
         ST_TX_DST: begin
            is_last = (di == last_used(r_reg.used));
            if (!r_reg.used[di]) begin
               r_next.idx = r_reg.idx + 1'b1;
            end else if (can_emit) begin
               r_next.tx_valid = 1'b1;
               r_next.tx_data  = {r_reg.dst[di], is_last ? EXT_LAST : EXT_MORE}; // [R3] [R5]
               r_next.tx_last  = 1'b0;
               r_next.idx      = r_reg.idx + 1'b1;
               if (is_last) begin
                  r_next.state = ST_TX_CTL;
               end
            end
         end
         ST_TX_CTL: begin
            if (can_emit) begin
               r_next.tx_valid = 1'b1;
               r_next.tx_data  = UI_POLL_CTRL; // [R7] [R8]
               r_next.idx      = '0;
               if (r_reg.plen == '0) begin
                  r_next.tx_last = 1'b1;
                  r_next.timer   = ACK_LOAD; // [R9]
                  r_next.state   = ST_WAIT;
               end else begin
                  r_next.tx_last = 1'b0;
                  r_next.state   = ST_TX_PAY;
               end
            end
         end
         ST_TX_PAY: begin
            if (can_emit) begin
               is_last         = (r_reg.idx == r_reg.plen - 1'b1);
               r_next.tx_valid = 1'b1;
               r_next.tx_data  = r_reg.pay[r_reg.idx[PAY_IDX_W-2:0]]; // [R8]
               r_next.tx_last  = is_last;
               r_next.idx      = r_reg.idx + 1'b1;
               if (is_last) begin
                  r_next.timer = ACK_LOAD; // [R9] [R10]
                  r_next.state = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (r_reg.pend == '0 && !r_reg.tx_valid) begin
               r_next.state      = ST_IDLE; // [R15] [R17]
               r_next.timer      = '0;
               r_next.txcnt      = '0;
               r_next.done_valid = 1'b1;
               r_next.done_code  = DONE_OK;
            end else if (r_reg.timer != '0) begin
               r_next.timer = r_reg.timer - 1'b1;
            end else if (r_reg.txcnt == N4_MAX) begin
               r_next.state      = ST_IDLE; // [R14]
               r_next.done_valid = 1'b1;
               r_next.done_code  = DONE_ACK_FAIL;
            end else begin
               for (int i = 0; i < MAX_DEST; i++) begin
                  keep[i] = r_reg.used[i] && ((expects_ack(r_reg.dst[i]) && r_reg.pend[i])
                            || r_reg.dst[i] == SPECIAL_ACKLESS); // [R11] [R12]
                  if (keep[i] && r_reg.dst[i] != SPECIAL_ACKLESS) begin
                     eligible = 1'b1;
                  end
               end
               if (eligible) begin
                  r_next.used  = keep; // [R11]
                  r_next.txcnt = r_reg.txcnt + 1'b1; // [R10] [R16]
                  r_next.state = ST_TX_SRC;
               end else begin
                  r_next.state      = ST_IDLE; // [R13] [R12]
                  r_next.done_valid = 1'b1;
                  r_next.done_code  = DONE_NO_RETRY;
               end
            end
            if (r_next.state == ST_IDLE) begin
               r_next.used = '0;
               r_next.pend = '0;
               r_next.ndst = '0;
               r_next.plen = '0;
            end
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_reg <= '{state: ST_IDLE, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : ack_connectionless_ui_sender

// ### remote_peers.sv
// Behavioural remote stations that answer polled UI frames
`timescale 1ns/10ps
module remote_peers
   import ui_sender_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       slow,
   input  wire logic [6:0] peer0_addr,
   input  wire logic [6:0] peer1_addr,
   input  wire logic [1:0] peer_en,
   input  wire logic       peer1_urnr,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic            resp_valid,
   output logic      [6:0] resp_src,
   output logic            resp_cr,
   output logic      [7:0] resp_ctrl
);
   logic [7:0] cyc = 8'h00;
   logic [1:0] st;
   logic [1:0] seen;
   logic [3:0] wt;

   assign tx_ready = !slow || cyc[1];

   always @(posedge ref_clk) begin
      cyc        <= cyc + 8'h01;
      resp_valid <= 1'b0;
      resp_src   <= cyc[6:0];   // Idle lines keep moving
      resp_cr    <= cyc[0];
      resp_ctrl  <= ~cyc;
      if (reset) begin
         st   <= 2'h0;
         seen <= 2'h0;
         wt   <= 4'h0;
      end else begin
         if (wt != 4'h0) wt <= wt - 4'h1;
         if (tx_valid && tx_ready) begin
            if (st == 2'h0) begin
               st   <= 2'h1;
               seen <= 2'h0;
            end else if (st == 2'h1) begin
               seen <= seen | {tx_data[7:1] == peer1_addr, tx_data[7:1] == peer0_addr};
               if (tx_data[0]) st <= 2'h2;
            end
            if (tx_last) begin
               st <= 2'h0;
               wt <= slow ? 4'h9 : 4'h2;
            end
         end
         if (wt == 4'h2 && seen[0] && peer_en[0]) begin
            resp_valid <= 1'b1;
            resp_src   <= peer0_addr;
            resp_cr    <= CR_RESPONSE;
            resp_ctrl  <= URR_CTRL;
         end
         if (wt == 4'h1 && seen[1] && peer_en[1]) begin
            resp_valid <= 1'b1;
            resp_src   <= peer1_addr;
            resp_cr    <= CR_RESPONSE;
            resp_ctrl  <= peer1_urnr ? URNR_CTRL : URR_CTRL;
         end
      end
   end
endmodule : remote_peers

// ### tb.sv
// Self-checking bench for the UI sender against remote peers
`timescale 1ns/10ps
module tb;
   import ui_sender_pkg::*;
   logic       ref_clk = 1'b0, reset = 1'b1, slow = 1'b0, peer1_urnr = 1'b0;
   logic [6:0] src_addr = 7'h05, dest_addr = 7'h00, t1_stat_addr = 7'h00, stat_query_addr = 7'h10;
   logic [6:0] peer0_addr = 7'h10, peer1_addr = 7'h11, resp_src;
   logic       dest_valid = 1'b0, pay_valid = 1'b0, pay_last = 1'b0, t1_stat_valid = 1'b0, t1_stat_busy = 1'b0;
   logic [7:0] pay_data = 8'h00, tx_data, resp_ctrl;
   logic [1:0] peer_en = 2'h0, done_code;
   logic       dest_ready, pay_ready, tx_valid, tx_last, tx_ready, resp_valid, resp_cr;
   logic       stat_busy, done_valid, engine_busy;
   int         error_cnt = 0, check_count = 0;
   logic [8:0] exp_tx[$];
   logic [1:0] exp_done[$];
   logic [6:0] dl[$];
   logic [7:0] pay[$];

   always #2 ref_clk = ~ref_clk;

   ack_connectionless_ui_sender #(.ACK_TICKS(20), .N4(3)) uut (.ref_clk, .reset, .src_addr, .dest_valid,
      .dest_addr, .dest_ready, .pay_valid, .pay_data, .pay_last, .pay_ready, .tx_valid, .tx_data, .tx_last,
      .tx_ready, .resp_valid, .resp_src, .resp_cr, .resp_ctrl, .t1_stat_valid, .t1_stat_addr, .t1_stat_busy,
      .stat_query_addr, .stat_busy, .done_valid, .done_code, .engine_busy);
   remote_peers peers (.ref_clk, .reset, .slow, .peer0_addr, .peer1_addr, .peer_en, .peer1_urnr, .tx_valid,
      .tx_data, .tx_last, .tx_ready, .resp_valid, .resp_src, .resp_cr, .resp_ctrl);

   task automatic cmp_byte(input logic [8:0] e, input logic [8:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t byte exp %h got %h", $time, e, g);
      end
   endtask : cmp_byte

   task automatic cmp_stat(input logic [1:0] e, input logic [1:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t status exp %h got %h", $time, e, g);
      end
   endtask : cmp_stat

   task automatic report_and_stop;
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic push_frame(input logic [6:0] s);
      exp_tx.push_back({1'b0, s, CR_COMMAND});
      foreach (dl[i]) exp_tx.push_back({1'b0, dl[i], i == dl.size() - 1});
      exp_tx.push_back({pay.size() == 0, UI_POLL_CTRL});
      foreach (pay[i]) exp_tx.push_back({i == pay.size() - 1, pay[i]});
   endtask : push_frame

   task automatic send_pay(input logic [7:0] d, input logic l);
      pay_valid = 1'b1;
      pay_data  = d;
      pay_last  = l;
      while (pay_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
   endtask : send_pay

   // Destinations go in before the closing payload byte
   task automatic start_xfer(input logic [6:0] s, input int n, input logic [1:0] code, input logic tx);
      src_addr = s;
      pay.delete();
      repeat (n) pay.push_back(8'($urandom));
      if (tx) push_frame(s);
      exp_done.push_back(code);
      foreach (dl[i]) begin
         dest_valid = 1'b1;
         dest_addr  = dl[i];
         while (dest_ready !== 1'b1) @(negedge ref_clk);
         @(negedge ref_clk);
      end
      dest_valid = 1'b0;
      foreach (pay[i]) send_pay(pay[i], i == n - 1);
      pay_valid = 1'b0;
   endtask : start_xfer

   task automatic wait_idle;
      int k = 0;
      while ((exp_tx.size() != 0 || exp_done.size() != 0) && k < 3000) begin
         @(negedge ref_clk);
         k++;
      end
      if (k == 3000) begin
         error_cnt++;
         $display("ERROR %0t pending exp %h got %h", $time, exp_tx.size(), exp_done.size());
      end
      repeat (4) @(negedge ref_clk);
   endtask : wait_idle

   always @(posedge ref_clk) begin
      if (!reset && tx_valid && tx_ready) begin
         cmp_byte(exp_tx.size() != 0 ? exp_tx.pop_front() : 9'hXXX, {tx_last, tx_data});
      end
      if (!reset && done_valid) begin
         cmp_stat(exp_done.size() != 0 ? exp_done.pop_front() : 2'hX, done_code);
      end
   end

   // Whole run needs a few hundred cycles
   initial begin
      #80000;
      error_cnt++;
      report_and_stop;
   end

   initial begin
      void'($urandom(32'h79E0F2AE));
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      cmp_stat(2'h3, {pay_ready, dest_ready});
      t1_stat_addr  = 7'h10;
      t1_stat_busy  = 1'b1;
      t1_stat_valid = 1'b1;
      @(negedge ref_clk);
      t1_stat_valid = 1'b0;
      repeat (2) @(negedge ref_clk);
      cmp_stat(2'h1, {1'b0, stat_busy});
      slow    = 1'b1;
      peer_en = 2'h3;
      dl      = '{7'h10, 7'h11};
      start_xfer(7'h05, 1 + ($urandom % 4), DONE_OK, 1'b1);
      wait_idle();
      cmp_stat(2'h0, {1'b0, stat_busy});
      slow            = 1'b0;
      peer_en         = 2'h2;
      peer1_urnr      = 1'b1;
      stat_query_addr = 7'h11;
      dl              = '{7'h10, 7'h11, GROUP_LO, GLOBAL_ADDR, SPECIAL_ACKLESS};
      start_xfer(7'h02, PAY_DEPTH, DONE_ACK_FAIL, 1'b1);
      dl = '{7'h10, SPECIAL_ACKLESS};
      repeat (3) push_frame(7'h02);
      exp_done.push_back(DONE_REJECT);
      @(negedge ref_clk);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         send_pay(8'(i), i == FIFO_DEPTH - 1);
      end
      pay_valid = 1'b0;
      cmp_stat(2'h0, {1'b0, pay_ready});
      wait_idle();
      cmp_stat(2'h1, {1'b0, stat_busy});
      cmp_stat(2'h1, {1'b0, pay_ready});
      dl = '{GROUP_LO, SPECIAL_ACKLESS};
      start_xfer(7'h06, 2, DONE_OK, 1'b1);
      wait_idle();
      for (int i = 0; i < 2; i++) begin
         dl = '{7'h10};
         start_xfer(i == 0 ? 7'h65 : GLOBAL_ADDR, 1, DONE_REJECT, 1'b0);
         wait_idle();
      end
      report_and_stop;
   end
endmodule : tb

// ### ui_fifo.sv
// Parameterised valid/ready FIFO between upper layer and sender
`timescale 1ns/10ps
module ui_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int PTR_W = $clog2(DEPTH) + 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr;
      logic [PTR_W-1:0]            rd;
   } fifo_state_t;

   fifo_state_t r_reg;
   fifo_state_t r_next;
   logic        full;
   logic        empty;

   assign empty     = (r_reg.wr == r_reg.rd);
   assign full      = (r_reg.wr[PTR_W-2:0] == r_reg.rd[PTR_W-2:0]) && (r_reg.wr[PTR_W-1] != r_reg.rd[PTR_W-1]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = r_reg.mem[r_reg.rd[PTR_W-2:0]];

   always_comb begin
      r_next = r_reg;
      if (in_valid && !full) begin
         r_next.mem[r_reg.wr[PTR_W-2:0]] = in_data;
         r_next.wr = r_reg.wr + 1'b1;
      end
      if (out_ready && !empty) begin
         r_next.rd = r_reg.rd + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_reg.mem <= '0;
         r_reg.wr  <= '0;
         r_reg.rd  <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : ui_fifo

// ### ui_sender_pkg.sv
// Shared constants and types for the acknowledged connectionless UI sender
package ui_sender_pkg;

   // Address layout
   localparam int ADDR_W          = 7;
   localparam int BYTE_W          = 8;
   localparam int STATIONS        = 128;
   localparam logic [6:0] GLOBAL_ADDR     = 7'h7F;
   localparam logic [6:0] SPECIAL_HI      = 7'h03;
   localparam logic [6:0] SPECIAL_ACKLESS = 7'h03;
   localparam logic [6:0] GROUP_LO        = 7'h60;
   localparam logic [6:0] GROUP_HI        = 7'h7E;

   // Leading address bit values
   localparam logic CR_COMMAND  = 1'b0;
   localparam logic CR_RESPONSE = 1'b1;
   localparam logic EXT_MORE    = 1'b0;
   localparam logic EXT_LAST    = 1'b1;

   // Control field codes, poll/final bit included
   localparam logic [7:0] UI_POLL_CTRL = 8'h13;
   localparam logic [7:0] URR_CTRL     = 8'hB3;
   localparam logic [7:0] URNR_CTRL    = 8'hBB;

   // Sizes
   localparam int MAX_DEST   = 8;
   localparam int DEST_IDX_W = 3;
   localparam int PAY_DEPTH  = 16;
   localparam int PAY_IDX_W  = 5;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W     = 9;
   localparam int CNT_W      = 8;
   localparam int TIMER_W    = 32;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int ACK_TIME_NS   = 100000;
   localparam int ACK_CYCLES    = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int N4_DEFAULT    = 3;

   // Completion codes
   localparam logic [1:0] DONE_OK       = 2'h0;
   localparam logic [1:0] DONE_ACK_FAIL = 2'h1;
   localparam logic [1:0] DONE_REJECT   = 2'h2;
   localparam logic [1:0] DONE_NO_RETRY = 2'h3;

   typedef enum logic [1:0] {
      AK_INDIVIDUAL,
      AK_GROUP,
      AK_SPECIAL,
      AK_GLOBAL
   } addr_kind_t;

   function automatic addr_kind_t addr_kind(input logic [6:0] a);
      if (a == GLOBAL_ADDR) begin
         return AK_GLOBAL;
      end else if (a <= SPECIAL_HI) begin
         return AK_SPECIAL;
      end else if (a >= GROUP_LO && a <= GROUP_HI) begin
         return AK_GROUP;
      end
      return AK_INDIVIDUAL;
   endfunction : addr_kind

endpackage : ui_sender_pkg

// ### ui_sender_properties.sv
// Port-level assertions for the acknowledged UI sender
`timescale 1ns/10ps
module ui_sender_properties
   import ui_sender_pkg::*;
#(
   parameter int ACK_TICKS = 20,
   parameter int N4        = 3
) (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic [6:0] src_addr,
   input wire logic       dest_ready,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_last,
   input wire logic       tx_ready,
   input wire logic       resp_valid,
   input wire logic [6:0] resp_src,
   input wire logic       resp_cr,
   input wire logic [7:0] resp_ctrl,
   input wire logic       t1_stat_valid,
   input wire logic [6:0] t1_stat_addr,
   input wire logic       t1_stat_busy,
   input wire logic [6:0] stat_query_addr,
   input wire logic       stat_busy,
   input wire logic       done_valid,
   input wire logic [1:0] done_code,
   input wire logic       engine_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic [1:0]  pos_reg;
   logic        sent_reg;
   logic [15:0] gap_reg;
   logic [3:0]  frames_reg;
   wire         hs = tx_valid && tx_ready;

   // Byte position in frame: source, destinations, control, payload
   always_ff @(posedge ref_clk) begin
      if (reset || (hs && tx_last)) begin
         pos_reg <= 2'h0;
      end else if (hs) begin
         pos_reg <= (pos_reg == 2'h0) ? 2'h1 : (pos_reg == 2'h1) ? (tx_data[0] ? 2'h2 : 2'h1) : 2'h3;
      end
      if (reset || done_valid) begin
         frames_reg <= 4'h0;
      end else if (hs && tx_last) begin
         frames_reg <= frames_reg + 4'h1;
      end
      if (reset || !engine_busy) begin
         sent_reg <= 1'b0;
         gap_reg  <= 16'h0;
      end else if (hs && tx_last) begin
         sent_reg <= 1'b1;
         gap_reg  <= 16'h0;
      end else if (!tx_valid) begin
         gap_reg <= gap_reg + 16'h1;
      end
   end

   a_reset_idle: assert property ($fell(reset) |-> !tx_valid && !done_valid && done_code == 2'h0 && !engine_busy)
      else $error("outputs not idle after reset");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("frame byte changed before acceptance");
   a_src_field: assert property (tx_valid && pos_reg == 2'h0 |-> tx_data == {src_addr, CR_COMMAND})
      else $error("source byte wrong");
   a_src_class: assert property (tx_valid && pos_reg == 2'h0 |->
      addr_kind(tx_data[7:1]) inside {AK_INDIVIDUAL, AK_SPECIAL})
      else $error("group or global source sent");
   a_poll_ctrl: assert property (tx_valid && pos_reg == 2'h2 |-> tx_data == UI_POLL_CTRL)
      else $error("control byte not UI with poll");
   a_tx_busy: assert property (tx_valid |-> engine_busy)
      else $error("byte sent while engine idle");
   a_dest_refuse: assert property (engine_busy |-> !dest_ready)
      else $error("destination accepted mid exchange");
   a_done_pulse: assert property (done_valid |=> !done_valid)
      else $error("completion pulse too long");
   a_retx_late: assert property ($rose(tx_valid) && sent_reg |-> gap_reg >= ACK_TICKS - 2)
      else $error("resend before timer expiry");
   a_wait_bound: assert property (gap_reg <= ACK_TICKS + 6)
      else $error("wait outlasts timer");
   a_fail_count: assert property (done_valid && done_code == DONE_ACK_FAIL |-> frames_reg == N4 + 1)
      else $error("failure after wrong frame count");
   a_urnr_busy: assert property ((resp_valid && resp_cr && resp_ctrl == URNR_CTRL && resp_src == stat_query_addr
      && !t1_stat_valid) ##1 ($stable(stat_query_addr) && !t1_stat_valid && !resp_valid) |=> stat_busy)
      else $error("busy peer not recorded");
   a_t1_record: assert property ((t1_stat_valid && t1_stat_addr == stat_query_addr && !resp_valid)
      ##1 ($stable(stat_query_addr) && !t1_stat_valid && !resp_valid) |=> stat_busy == $past(t1_stat_busy, 2))
      else $error("type 1 status not shared");
endmodule : ui_sender_properties

bind ack_connectionless_ui_sender ui_sender_properties #(.ACK_TICKS(ACK_TICKS), .N4(N4)) props (
   .ref_clk, .reset, .src_addr, .dest_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .resp_valid,
   .resp_src, .resp_cr, .resp_ctrl, .t1_stat_valid, .t1_stat_addr, .t1_stat_busy, .stat_query_addr,
   .stat_busy, .done_valid, .done_code, .engine_busy);
